// File: rtl/mfsl_map.svh
// Purpose: Bit positions and reset values of the low fault status flags
// Assumes: Included by the flag block; the package does not include it
// Notes: Bits 6:4 and 2 read zero
`ifndef MFSL_MAP_SVH
`define MFSL_MAP_SVH
`define MFSL_BIT_IACC 0
`define MFSL_BIT_DACC 1
`define MFSL_BIT_RSVD 2
`define MFSL_BIT_UNSTK 3
`define MFSL_BIT_VALID 7
`define MFSL_FLAGS_RST 8'h00
`define MFSL_ADDR_RST 32'h0000_0000
`endif

// File: rtl/mfsl_pkg.sv
// Purpose: Types of the low fault status flag block
// Assumes: Map header holds the numbers
// Notes: None
package mfsl_pkg;
  // Fault events from the core
  typedef struct packed {
    logic unstack_viol;
    logic data_viol;
    logic fetch_viol;
    logic fetch_xn;
    logic [31:0] data_addr;
  } mfsl_event_t;
  // Exception logic directives
  typedef struct packed {
    logic chain_to_handler;
    logic keep_return_stack;
    logic hold_stack_pointer;
    logic skip_context_save;
    logic stack_faulting_pc;
    logic load_fault_addr;
  } mfsl_action_t;
  typedef enum logic [1:0] {
    MFSL_NONE,
    MFSL_UNSTK,
    MFSL_DACC,
    MFSL_IACC
  } mfsl_kind_t;
endpackage

// File: rtl/mfsl_flags.sv
// Purpose: Sticky low memory fault flags with write-one-to-clear
// Assumes: Events and clears are one-cycle pulses synchronous to sys_clk
// Notes: Set wins over clear in the same cycle
`timescale 1ns/100ps
`include "mfsl_map.svh"
// What this block does
// RULE1: Unstacking access violation on exception return sets bit 3 flag.
// RULE2: Unstack fault chains to handler, keeps return stack and stack pointer.
// RULE3: Unstack fault does no new context save and no address capture.
// RULE4: Violation flags are sticky; writing one clears, zero leaves them.
// RULE5: Bit 2 reads zero always and ignores writes.
// RULE6: Forbidden load or store sets data access violation flag, bit 1.
// RULE7: Data fault stacks faulting program counter and captures access address.
// RULE8: Fetch from non-executable location sets instruction violation flag, bit 0.
// RULE9: Execute-never fetch faults even with protection unit off or absent.
// RULE10: Instruction fault stacks faulting program counter, captures no address.
// RULE11: Bit 7 marks captured address valid; cleared by writing one.
// RULE12: Hardware set beats a simultaneous software clear.
module mfsl_flags import mfsl_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Core fault events
  input wire mfsl_event_t fault_in,
  input wire logic mpu_enable,
  // Software write port
  input wire logic status_wr,
  input wire logic [7:0] status_wdata,
  // Status and address outputs
  output logic [7:0] status_rdata,
  output logic [31:0] mem_fault_address_reg,
  // Exception logic directives
  output mfsl_action_t action,
  output mfsl_kind_t fault_kind
);

  logic unstack_violation_flag;
  logic data_access_violation_flag;
  logic instruction_access_violation_flag;
  logic fault_address_valid_flag;
  logic fetch_hit;
  logic [7:0] clr;

  function automatic logic next_sticky(input logic cur, input logic set, input logic c);
    next_sticky = set | (cur & ~c);
  endfunction

  // Execute-never applies regardless of protection unit state
  assign fetch_hit = fault_in.fetch_xn | (fault_in.fetch_viol & mpu_enable); // RULE9
  assign clr = status_wr ? status_wdata : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      unstack_violation_flag <= 1'b0;
    end else begin
      unstack_violation_flag <= next_sticky(unstack_violation_flag, fault_in.unstack_viol,
        clr[`MFSL_BIT_UNSTK]); // RULE1 RULE4 RULE12
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      data_access_violation_flag <= 1'b0;
    end else begin
      data_access_violation_flag <= next_sticky(data_access_violation_flag,
        fault_in.data_viol, clr[`MFSL_BIT_DACC]); // RULE6 RULE4 RULE12
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      instruction_access_violation_flag <= 1'b0;
    end else begin
      instruction_access_violation_flag <= next_sticky(instruction_access_violation_flag,
        fetch_hit, clr[`MFSL_BIT_IACC]); // RULE8 RULE4 RULE12
    end
  end

  // Address capture only for data faults
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      fault_address_valid_flag <= 1'b0;
      mem_fault_address_reg <= `MFSL_ADDR_RST;
    end else begin
      fault_address_valid_flag <= next_sticky(fault_address_valid_flag, fault_in.data_viol,
        clr[`MFSL_BIT_VALID]); // RULE11 RULE12
      if (fault_in.data_viol) begin
        mem_fault_address_reg <= fault_in.data_addr; // RULE7
      end
    end
  end

  // Status byte, reserved bits zero
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      status_rdata <= `MFSL_FLAGS_RST;
    end else begin
      status_rdata <= 8'h00;
      status_rdata[`MFSL_BIT_VALID] <= next_sticky(fault_address_valid_flag,
        fault_in.data_viol, clr[`MFSL_BIT_VALID]);
      status_rdata[`MFSL_BIT_UNSTK] <= next_sticky(unstack_violation_flag,
        fault_in.unstack_viol, clr[`MFSL_BIT_UNSTK]);
      status_rdata[`MFSL_BIT_RSVD] <= 1'b0; // RULE5
      status_rdata[`MFSL_BIT_DACC] <= next_sticky(data_access_violation_flag,
        fault_in.data_viol, clr[`MFSL_BIT_DACC]);
      status_rdata[`MFSL_BIT_IACC] <= next_sticky(instruction_access_violation_flag,
        fetch_hit, clr[`MFSL_BIT_IACC]);
    end
  end

  // Directives to exception logic, registered one cycle after the event
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      action <= '0;
      fault_kind <= MFSL_NONE;
    end else begin
      action <= '0;
      fault_kind <= MFSL_NONE;
      if (fault_in.unstack_viol) begin
        action.chain_to_handler <= 1'b1; // RULE2
        action.keep_return_stack <= 1'b1; // RULE2
        action.hold_stack_pointer <= 1'b1; // RULE2
        action.skip_context_save <= 1'b1; // RULE3
        fault_kind <= MFSL_UNSTK;
      end else if (fault_in.data_viol) begin
        action.stack_faulting_pc <= 1'b1; // RULE7
        action.load_fault_addr <= 1'b1; // RULE7
        fault_kind <= MFSL_DACC;
      end else if (fetch_hit) begin
        action.stack_faulting_pc <= 1'b1; // RULE10
        fault_kind <= MFSL_IACC;
      end
    end
  end

  // Event and clear sequences
  sequence s_unstk;
    fault_in.unstack_viol;
  endsequence

  sequence s_data;
    fault_in.data_viol;
  endsequence

  sequence s_fetch_only;
    fetch_hit && !fault_in.unstack_viol && !fault_in.data_viol;
  endsequence

  sequence s_data_clear;
    status_wr && status_wdata[`MFSL_BIT_DACC] && !fault_in.data_viol;
  endsequence

  sequence s_data_then_clear;
    s_data ##1 s_data_clear;
  endsequence

  chk_unstk_sets: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE1
    s_unstk
    |=> unstack_violation_flag && status_rdata[`MFSL_BIT_UNSTK])
    else $error("unstack flag not set");

  chk_unstk_chain: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE2
    s_unstk
    |=> action.chain_to_handler && action.keep_return_stack && action.hold_stack_pointer)
    else $error("unstack not chained");

  chk_unstk_kind: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE2
    s_unstk
    |=> fault_kind == MFSL_UNSTK && !action.stack_faulting_pc)
    else $error("unstack kind wrong");

  chk_unstk_noaddr: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE3
    (s_unstk and !fault_in.data_viol)
    |=> action.skip_context_save && !action.load_fault_addr && $stable(mem_fault_address_reg))
    else $error("unstack captured address");

  chk_addr_hold: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE3 RULE10
    !fault_in.data_viol
    |=> $stable(mem_fault_address_reg))
    else $error("address changed without data fault");

  chk_action_idle: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE3
    !fault_in.unstack_viol && !fault_in.data_viol && !fetch_hit
    |=> action == '0 && fault_kind == MFSL_NONE)
    else $error("directive without event");

  chk_flag_sticky: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE4
    data_access_violation_flag && !(status_wr && status_wdata[`MFSL_BIT_DACC])
    |=> data_access_violation_flag)
    else $error("data flag lost");

  chk_unstk_sticky: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE4
    unstack_violation_flag && !(status_wr && status_wdata[`MFSL_BIT_UNSTK])
    |=> unstack_violation_flag)
    else $error("unstack flag lost");

  chk_fetch_sticky: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE4
    instruction_access_violation_flag && !(status_wr && status_wdata[`MFSL_BIT_IACC])
    |=> instruction_access_violation_flag)
    else $error("fetch flag lost");

  chk_data_clear: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE4
    s_data_clear
    |=> !data_access_violation_flag && !status_rdata[`MFSL_BIT_DACC])
    else $error("data flag not cleared");

  chk_unstk_clear: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE4
    status_wr && status_wdata[`MFSL_BIT_UNSTK] && !fault_in.unstack_viol
    |=> !unstack_violation_flag && !status_rdata[`MFSL_BIT_UNSTK])
    else $error("unstack flag not cleared");

  chk_fetch_clear: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE4
    status_wr && status_wdata[`MFSL_BIT_IACC] && !fetch_hit
    |=> !instruction_access_violation_flag && !status_rdata[`MFSL_BIT_IACC])
    else $error("fetch flag not cleared");

  chk_clear_walk: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE4 RULE7
    s_data_then_clear
    |=> !data_access_violation_flag && mem_fault_address_reg == $past(fault_in.data_addr, 2))
    else $error("data clear walk failed");

  chk_rsvd_zero: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE5
    1'b1
    |-> status_rdata[`MFSL_BIT_RSVD] == 1'b0)
    else $error("reserved bit nonzero");

  chk_status_mirror: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE5
    1'b1
    |-> status_rdata == {fault_address_valid_flag, 3'b000, unstack_violation_flag, 1'b0,
      data_access_violation_flag, instruction_access_violation_flag})
    else $error("status byte mismatch");

  chk_reset_clear: assert property (@(posedge sys_clk) // RULE5
    !rstn
    |=> status_rdata == `MFSL_FLAGS_RST && action == '0 && fault_kind == MFSL_NONE)
    else $error("reset left state");

  chk_data_capture: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE6 RULE7
    s_data
    |=> data_access_violation_flag && mem_fault_address_reg == $past(fault_in.data_addr))
    else $error("data fault not captured");

  chk_data_only: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE6
    !data_access_violation_flag && !fault_in.data_viol
    |=> !data_access_violation_flag)
    else $error("data flag set without event");

  chk_data_action: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE7
    (s_data and !fault_in.unstack_viol)
    |=> action.stack_faulting_pc && action.load_fault_addr && fault_kind == MFSL_DACC)
    else $error("data fault directive wrong");

  chk_fetch_sets: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE8 RULE9
    fault_in.fetch_xn
    |=> instruction_access_violation_flag)
    else $error("fetch flag not set");

  chk_fetch_gated: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE8
    fault_in.fetch_viol && mpu_enable
    |=> instruction_access_violation_flag && status_rdata[`MFSL_BIT_IACC])
    else $error("protected fetch not flagged");

  chk_fetch_only: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE8
    !instruction_access_violation_flag && !fetch_hit
    |=> !instruction_access_violation_flag)
    else $error("fetch flag set without event");

  chk_xn_unprot: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE9
    fault_in.fetch_xn && !mpu_enable
    |=> instruction_access_violation_flag && status_rdata[`MFSL_BIT_IACC])
    else $error("execute-never fetch missed");

  chk_fetch_noaddr: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE10
    s_fetch_only
    |=> $stable(mem_fault_address_reg) && !action.load_fault_addr
      && ($past(fault_address_valid_flag) || !fault_address_valid_flag))
    else $error("fetch captured address");

  chk_fetch_action: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE10
    s_fetch_only
    |=> action.stack_faulting_pc && fault_kind == MFSL_IACC)
    else $error("fetch directive wrong");

  chk_valid_flag: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE11
    s_data
    |=> fault_address_valid_flag && status_rdata[`MFSL_BIT_VALID])
    else $error("valid flag not set");

  chk_valid_only: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE11
    !fault_address_valid_flag && !fault_in.data_viol
    |=> !fault_address_valid_flag)
    else $error("valid flag set without data fault");

  chk_valid_clear: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE11
    status_wr && status_wdata[`MFSL_BIT_VALID] && !fault_in.data_viol
    |=> !fault_address_valid_flag && !status_rdata[`MFSL_BIT_VALID])
    else $error("valid flag not cleared");

  chk_valid_sticky: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE11
    fault_address_valid_flag && !(status_wr && status_wdata[`MFSL_BIT_VALID])
    |=> fault_address_valid_flag)
    else $error("valid flag lost");

  chk_set_wins: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE12
    fault_in.unstack_viol && status_wr && status_wdata[`MFSL_BIT_UNSTK]
    |=> unstack_violation_flag)
    else $error("set lost to clear");

  chk_data_wins: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE12
    fault_in.data_viol && status_wr && status_wdata[`MFSL_BIT_DACC]
    |=> data_access_violation_flag)
    else $error("data set lost to clear");

  chk_fetch_wins: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE12
    fetch_hit && status_wr && status_wdata[`MFSL_BIT_IACC]
    |=> instruction_access_violation_flag)
    else $error("fetch set lost to clear");

  chk_valid_wins: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE12
    fault_in.data_viol && status_wr && status_wdata[`MFSL_BIT_VALID]
    |=> fault_address_valid_flag)
    else $error("valid set lost to clear");

endmodule // mfsl_flags

// File: testbench/mfsl_flags_tb_top.sv
// Purpose: Self-checking bench for the low fault status flags
// Assumes: Inputs change at the falling edge
// Notes: Driver queues expected results; monitor compares them
`timescale 1ns/100ps
module mfsl_flags_tb_top import mfsl_pkg::*; ;
  // Expected outputs of one cycle
  typedef struct packed {
    logic [7:0] st;
    logic [31:0] ad;
    mfsl_action_t ac;
    mfsl_kind_t k;
  } mfsl_exp_t;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  mfsl_event_t fault_in = '0;
  logic mpu_enable = 1'b0;
  logic status_wr = 1'b0;
  logic [7:0] status_wdata = 8'h00;
  logic [7:0] status_rdata;
  logic [31:0] mem_fault_address_reg;
  mfsl_action_t action;
  mfsl_kind_t fault_kind;
  mfsl_exp_t notes[$];
  mfsl_exp_t got;
  int failures = 0;
  int compares = 0;
  always #4 sys_clk = ~sys_clk;
  mfsl_flags dut_u (
    .sys_clk(sys_clk), .rstn(rstn), .fault_in(fault_in), .mpu_enable(mpu_enable),
    .status_wr(status_wr), .status_wdata(status_wdata), .status_rdata(status_rdata),
    .mem_fault_address_reg(mem_fault_address_reg), .action(action), .fault_kind(fault_kind)
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Monitor: one queued note per result cycle
  always @(posedge sys_clk) begin
    if (notes.size() > 0) begin
      got = notes.pop_front();
      #1;
      check(32'(status_rdata), 32'(got.st));
      check(mem_fault_address_reg, got.ad);
      check(32'(action), 32'(got.ac));
      check(32'(fault_kind), 32'(got.k));
    end
  end
  // Driver: random events and clears, model kept alongside
  initial begin
    logic [7:0] st;
    logic [31:0] ad;
    logic fv;
    int kd;
    mfsl_exp_t e;
    void'($urandom(32'hd5bec7c0));
    st = 8'h00;
    ad = 32'h0000_0000;
    repeat (16) @(negedge sys_clk);
    rstn = 1'b1;
    @(negedge sys_clk);
    check(32'(status_rdata), 32'h0000_0000);
    repeat (600) begin
      kd = $urandom_range(4, 0);
      fault_in = '0;
      fault_in.unstack_viol = (kd == 1);
      fault_in.data_viol = (kd == 2);
      fault_in.fetch_viol = (kd == 3);
      fault_in.fetch_xn = (kd == 4);
      fault_in.data_addr = $urandom();
      mpu_enable = 1'($urandom_range(1, 0));
      status_wr = ($urandom_range(3, 0) == 0);
      status_wdata = 8'($urandom());
      fv = (kd == 4) || (kd == 3 && mpu_enable);
      if (status_wr) begin
        st = st & ~status_wdata;
      end
      st = st | {kd == 2, 3'b000, kd == 1, 1'b0, kd == 2, fv};
      if (kd == 2) begin
        ad = fault_in.data_addr;
      end
      e.st = st;
      e.ad = ad;
      e.ac = kd == 1 ? 6'b111100 : kd == 2 ? 6'b000011 : fv ? 6'b000010 : 6'b000000;
      e.k = kd == 1 ? MFSL_UNSTK : kd == 2 ? MFSL_DACC : fv ? MFSL_IACC : MFSL_NONE;
      notes.push_back(e);
      @(negedge sys_clk);
    end
    // Mid-run reset clears flags and address
    rstn = 1'b0;
    fault_in = '0;
    status_wr = 1'b0;
    repeat (2) @(negedge sys_clk);
    rstn = 1'b1;
    @(negedge sys_clk);
    check(32'(status_rdata), 32'h0000_0000);
    check(mem_fault_address_reg, 32'h0000_0000);
    // All events at once with a full clear: priority and set-wins
    fault_in.unstack_viol = 1'b1;
    fault_in.data_viol = 1'b1;
    fault_in.fetch_xn = 1'b1;
    fault_in.data_addr = $urandom();
    status_wr = 1'b1;
    status_wdata = 8'hff;
    e.st = 8'h8b;
    e.ad = fault_in.data_addr;
    e.ac = 6'b111100;
    e.k = MFSL_UNSTK;
    notes.push_back(e);
    @(negedge sys_clk);
    // Writes to reserved bits only change nothing
    fault_in = '0;
    status_wdata = 8'h74;
    e.ac = 6'b000000;
    e.k = MFSL_NONE;
    notes.push_back(e);
    @(negedge sys_clk);
    // Clearing every flag, address stays
    status_wdata = 8'h8b;
    e.st = 8'h00;
    notes.push_back(e);
    @(negedge sys_clk);
    fault_in = '0;
    status_wr = 1'b0;
    repeat (3) @(negedge sys_clk);
    complete_run();
  end
  // Watchdog: about 620 cycles expected
  initial begin
    #(8 * 1000);
    failures++;
    complete_run();
  end
endmodule // mfsl_flags_tb_top
